// ===== rtl/whma_arbiter.sv
// Six-level weighted round-robin arbiter for the shared SDRAM bus
// Functional notes
// - each grant moves one fixed 64-byte block, the bandwidth unit
// - each granted transaction occupies the bus for 20 cycles, 30 when reordered
// - first processor transaction needing new bank order adds 10 cycles
// - refresh inserted between transactions at programmed interval, 19 cycles
// - video out/in, PCI, decoder raise priority after delay times 16 cpu cycles
// - clock ratios 5/4, 4/3, 3/2, 2/1, 1 convert raise delay to SDRAM cycles
// - each level shares grants between unit and lower branch by weight
// - requests ahead of a unit bounded by the level weight ratios
// - a disabled requester takes no grants; its slots go to others
// - real-time units set a sticky exception flag on over or underflow
// - an arbitration decision is made 4 SDRAM cycles before each transaction ends
// - work conserving: unused slots pass to other requesting units
// - default weights give processor half, video output a quarter
// - six fixed levels: cpu, video out, coproc, video in, PCI, bottom
// - processor register, data and instruction requests by fixed priority
// - weights come from one register of two-bit and one-bit fields
// - the weight register clears to zero on reset, all weights one
`timescale 1ns/1ps
module whma_arbiter (
  input wire logic core_clk, // SDRAM clock
  input wire logic srst, // synchronous reset, active high
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic [20:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // write byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  input wire whma_pkg::whma_req_t req, // held until acked
  input wire logic cpu_reorder, // processor needs other bank order
  input wire whma_pkg::whma_fault_t rt_fault, // buffer over/underflow
  output whma_pkg::whma_req_t ack, // one-cycle grant pulse
  output logic mem_start, // transaction starts on the bus
  output logic [3:0] mem_owner, // index of last granted requester
  output logic [6:0] mem_bytes, // bytes per transaction
  output logic refresh_active // refresh occupies the bus
);
  import whma_pkg::*;

  logic [31:0] wctl_q, raise_q, cfg_q, rfsh_q, rdata_q;
  logic [4:0] exc_q;
  logic resp_q;
  whma_state_t st_q, st_d;
  logic [4:0] cnt_q, cnt_d, len_q, len_d, plen_q, plen_d, new_len;
  logic pend_q, pend_d, due_q, last_cpu_q, start_q;
  logic [15:0] rcnt_q;
  logic [11:0] ack_q, req_v, req_eff, raised_v, cand, grant_v;
  logic [3:0] own_q, raised4;
  logic [6:0] bytes_q;
  logic [2:0] p6_q, l6_win;
  logic [1:0] c6_q;
  logic l6_any;
  logic [2:0] wu [NLVL];
  logic [2:0] wl [NLVL];
  logic [4:0] ureq, lreq, pick;
  logic [5:0] reach;

  function automatic logic [31:0] be_merge(input logic [31:0] o,
    input logic [31:0] w, input logic [3:0] be);
    for (int b = 0; b < 4; b++)
      be_merge[8*b +: 8] = be[b] ? w[8*b +: 8] : o[8*b +: 8];
  endfunction

  // Weight codes 1,2,3 and odd 1,3,5(,7); unused code 11 clamps to the top
  function automatic logic [2:0] w_step(input logic [1:0] c);
    w_step = (c == 2'h3) ? 3'h3 : {1'b0, c} + 3'h1;
  endfunction
  function automatic logic [2:0] w_odd(input logic [1:0] c, input logic cap);
    w_odd = (cap && c == 2'h3) ? 3'h5 : {c, 1'b1};
  endfunction
  function automatic logic [3:0] enc(input logic [11:0] v);
    enc = 4'h0;
    for (int i = 0; i < NREQ; i++)
      if (v[i])
        enc = 4'(i);
  endfunction

  // Bus slave decode: every access answers after one wait cycle
  wire access = avs_read | avs_write;
  wire wr_fire = avs_write & resp_q;
  wire sel_wctl = avs_address == WCTL_OFS;
  wire sel_raise = avs_address == RAISE_OFS;
  wire sel_cfg = avs_address == CFG_OFS;
  wire sel_rfsh = avs_address == RFSH_OFS;
  wire sel_stat = avs_address == STAT_OFS;
  wire [31:0] stat_v = {16'h0000, own_q, 2'h0, 2'(st_q), 3'h0, exc_q};
  wire [31:0] rd_mux = sel_wctl ? wctl_q : sel_raise ? raise_q :
    sel_cfg ? cfg_q : sel_rfsh ? rfsh_q : sel_stat ? stat_v : 32'h00000000;
  wire [4:0] w1c = (wr_fire && sel_stat && avs_byteenable[0]) ?
    avs_writedata[4:0] : 5'h00;
  wire [4:0] exc_d = (exc_q & ~w1c) | rt_fault;
  assign avs_waitrequest = access & ~resp_q;
  assign avs_readdata = rdata_q;

  // Register file; a fault in the clearing cycle still sets its flag
  always_ff @(posedge core_clk)
    if (srst)
    begin
      wctl_q <= WCTL_RST;
      raise_q <= RAISE_RST;
      cfg_q <= CFG_RST;
      rfsh_q <= RFSH_RST;
      exc_q <= 5'h00;
      resp_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end
    else if (ce)
    begin
      resp_q <= access & ~resp_q;
      if (access && !resp_q)
        rdata_q <= rd_mux;
      if (wr_fire && sel_wctl)
        wctl_q <= be_merge(wctl_q, avs_writedata, avs_byteenable) & WCTL_MASK;
      if (wr_fire && sel_raise)
        raise_q <= be_merge(raise_q, avs_writedata, avs_byteenable) &
          RAISE_MASK;
      if (wr_fire && sel_cfg)
        cfg_q <= be_merge(cfg_q, avs_writedata, avs_byteenable) & CFG_MASK;
      if (wr_fire && sel_rfsh)
        rfsh_q <= be_merge(rfsh_q, avs_writedata, avs_byteenable) & RFSH_MASK;
      exc_q <= exc_d;
    end

  // Weight decode; all-zero register gives every branch weight one
  assign wu[0] = w_step(wctl_q[W_CPU_LSB +: 2]);
  assign wl[0] = w_step(wctl_q[W_L2_LSB +: 2]);
  assign wu[1] = w_odd(wctl_q[W_VO_LSB +: 2], 1'b1);
  assign wl[1] = w_odd(wctl_q[W_L3_LSB +: 2], 1'b0);
  assign wu[2] = w_odd(wctl_q[W_ICP_LSB +: 2], 1'b0);
  assign wl[2] = w_odd(wctl_q[W_L4_LSB +: 2], 1'b1);
  assign wu[3] = {2'h0, wctl_q[W_VI_BIT]} + 3'h1;
  assign wl[3] = w_odd(wctl_q[W_L5_LSB +: 2], 1'b1);
  assign wu[4] = w_odd(wctl_q[W_PCI_LSB +: 2], 1'b1);
  assign wl[4] = {2'h0, wctl_q[W_L6_BIT]} + 3'h1;

  // Disabled units drop out; ratio code above 4 falls back to 1
  wire [2:0] r_code = cfg_q[CFG_RATIO_LSB +: 3];
  wire [2:0] r_sel = (r_code > 3'h4) ? 3'h0 : r_code;
  wire [2:0] r_num = RATIO_NUM[3*r_sel +: 3];
  wire [2:0] r_den = RATIO_DEN[3*r_sel +: 3];
  assign req_v = req;
  assign req_eff = req_v & cfg_q[CFG_EN_LSB +: NREQ];

  // Raise timers count processor cycles in units of 1/den per SDRAM clock
  for (genvar r = 0; r < 4; r++)
  begin : g_raise
    localparam int RI = int'(RAISE_MAP[4*r +: 4]);
    logic [11:0] acc_q;
    wire [3:0] rval = raise_q[RAISE_FLD_W*r +: RAISE_FLD_W];
    wire [11:0] thr = 12'(rval) * RAISE_UNIT * 12'(r_den);
    assign raised4[r] = (rval != 4'h0) && (acc_q >= thr);
    always_ff @(posedge core_clk)
      if (srst)
        acc_q <= 12'h000;
      else if (ce)
      begin
        if (!req_eff[RI] || ack_q[RI])
          acc_q <= 12'h000;
        else if (!raised4[r])
          acc_q <= acc_q + 12'(r_num);
      end
  end
  assign raised_v = (12'(raised4[0]) << RAISE_MAP[3:0]) |
    (12'(raised4[1]) << RAISE_MAP[7:4]) |
    (12'(raised4[2]) << RAISE_MAP[11:8]) |
    (12'(raised4[3]) << RAISE_MAP[15:12]);
  // Raised requests win as a group, still ordered by the hierarchy
  assign cand = (|(req_eff & raised_v)) ? (req_eff & raised_v) : req_eff;

  // Decision points: idle, or mid-transaction so the next grant overlaps
  wire last_cyc = cnt_q == len_q - 5'h01;
  wire dec_pt = !due_q && ((st_q == ST_IDLE) || (st_q == ST_XFER &&
    cnt_q == len_q - (XFER_CYC - DECIDE_CYC) && !pend_q));
  wire dec_fire = dec_pt && (|cand);
  wire cpu_win = |grant_v[IDX_ICACHE:IDX_MMIO];
  wire l6_hit = reach[NLVL] && l6_any;

  // Levels 1-5: unit against everything below, weighted credits
  assign reach[0] = 1'b1;
  for (genvar k = 0; k < NLVL; k++)
  begin : g_lvl
    logic [2:0] uc_q, lc_q;
    logic rel, uok;
    if (k == 0)
    begin : g_top
      assign ureq[k] = |cand[IDX_ICACHE:IDX_MMIO];
    end
    else
    begin : g_mid
      assign ureq[k] = cand[k+2];
    end
    assign lreq[k] = |cand[NREQ-1:k+3];
    assign rel = (uc_q >= wu[k]) && (lc_q >= wl[k]);
    assign uok = rel || (uc_q < wu[k]);
    assign pick[k] = ureq[k] && (!lreq[k] || uok);
    assign reach[k+1] = reach[k] && !pick[k];
    always_ff @(posedge core_clk)
      if (srst)
      begin
        uc_q <= 3'h0;
        lc_q <= 3'h0;
      end
      else if (ce && dec_fire && reach[k])
      begin
        if (rel)
        begin
          uc_q <= {2'h0, pick[k]};
          lc_q <= {2'h0, !pick[k]};
        end
        else if (pick[k] && uc_q != 3'h7)
          uc_q <= uc_q + 3'h1;
        else if (!pick[k] && lc_q != 3'h7)
          lc_q <= lc_q + 3'h1;
      end
  end

  // Bottom level: rotating pointer, decoder slot 0 holds two turns
  always_comb
  begin
    int i6;
    i6 = 0;
    l6_any = 1'b0;
    l6_win = 3'h0;
    for (int j = 0; j < L6_N; j++)
    begin
      i6 = int'(p6_q) + j;
      if (i6 >= L6_N)
        i6 = i6 - L6_N;
      if (!l6_any && cand[L6_BASE + i6])
      begin
        l6_any = 1'b1;
        l6_win = 3'(i6);
      end
    end
  end
  wire [1:0] c6_new = (l6_win == p6_q) ? c6_q + 2'h1 : 2'h1;
  wire [1:0] w6 = (l6_win == 3'h0) ? 2'h2 : 2'h1;
  wire [2:0] p6_next = (l6_win == 3'(L6_N - 1)) ? 3'h0 : l6_win + 3'h1;

  // Single winner; processor sources by fixed priority
  always_comb
  begin
    grant_v = 12'h000;
    if (pick[0])
    begin
      if (cand[IDX_MMIO])
        grant_v[IDX_MMIO] = 1'b1;
      else if (cand[IDX_DCACHE])
        grant_v[IDX_DCACHE] = 1'b1;
      else
        grant_v[IDX_ICACHE] = 1'b1;
    end
    for (int k = 1; k < NLVL; k++)
      if (reach[k] && pick[k])
        grant_v[k+2] = 1'b1;
    if (l6_hit)
      grant_v[L6_BASE + int'(l6_win)] = 1'b1;
  end

  // First processor transaction after another owner may need reordering
  assign new_len = (cpu_win && cpu_reorder && !last_cpu_q) ?
    XFER_CYC + EXTRA_CYC : XFER_CYC;

  // Bus sequencer: transactions back to back, refresh only between them
  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q + 5'h01;
    len_d = len_q;
    pend_d = pend_q;
    plen_d = plen_q;
    case (st_q)
      ST_IDLE:
      begin
        cnt_d = 5'h00;
        if (due_q)
          st_d = ST_RFSH;
        else if (dec_fire)
        begin
          st_d = ST_XFER;
          len_d = new_len;
        end
      end
      ST_XFER:
      begin
        if (dec_fire)
        begin
          pend_d = 1'b1;
          plen_d = new_len;
        end
        if (last_cyc)
        begin
          cnt_d = 5'h00;
          pend_d = 1'b0;
          len_d = plen_q;
          st_d = pend_q ? ST_XFER : due_q ? ST_RFSH : ST_IDLE;
        end
      end
      ST_RFSH:
        if (cnt_q == RFSH_CYC - 5'h01)
          st_d = ST_IDLE;
      default:
        st_d = ST_IDLE;
    endcase
  end
  wire start_d = (st_q == ST_IDLE && dec_fire) ||
    (st_q == ST_XFER && last_cyc && pend_q);
  wire rf_hit = ({1'b0, rcnt_q} + 17'h00001) >= {1'b0, rfsh_q[15:0]};
  wire enter_rf = st_d == ST_RFSH && st_q != ST_RFSH;

  always_ff @(posedge core_clk)
    if (srst)
    begin
      st_q <= ST_IDLE;
      cnt_q <= 5'h00;
      len_q <= XFER_CYC;
      pend_q <= 1'b0;
      plen_q <= XFER_CYC;
      due_q <= 1'b0;
      rcnt_q <= 16'h0000;
      start_q <= 1'b0;
    end
    else if (ce)
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      len_q <= len_d;
      pend_q <= pend_d;
      plen_q <= plen_d;
      rcnt_q <= rf_hit ? 16'h0000 : rcnt_q + 16'h0001;
      due_q <= rf_hit | (due_q & ~enter_rf);
      start_q <= start_d;
    end

  // Grant bookkeeping and the bottom-level pointer
  always_ff @(posedge core_clk)
    if (srst)
    begin
      ack_q <= 12'h000;
      own_q <= 4'h0;
      bytes_q <= 7'h00;
      last_cpu_q <= 1'b0;
      p6_q <= 3'h0;
      c6_q <= 2'h0;
    end
    else if (ce)
    begin
      ack_q <= dec_fire ? grant_v : 12'h000;
      if (dec_fire)
      begin
        own_q <= enc(grant_v);
        bytes_q <= XFER_BYTES;
        last_cpu_q <= cpu_win;
      end
      if (dec_fire && l6_hit)
      begin
        p6_q <= (c6_new >= w6) ? p6_next : l6_win;
        c6_q <= (c6_new >= w6) ? 2'h0 : c6_new;
      end
    end

  assign ack = whma_req_t'(ce ? ack_q : 12'h000);
  assign mem_start = start_q & ce;
  assign mem_owner = own_q;
  assign mem_bytes = bytes_q;
  assign refresh_active = st_q == ST_RFSH;

  // Checks; the start gap stays zero until the first start after reset,
  // so the opening transaction is not judged against a slot it never had
  logic [4:0] gap_q;
  always_ff @(posedge core_clk)
    if (srst)
      gap_q <= 5'h00;
    else if (ce)
      gap_q <= mem_start ? 5'h01 : (gap_q == 5'h00 || gap_q == 5'h1F) ?
        gap_q : gap_q + 5'h01;

  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence rf_hold_s;
    refresh_active [*8] ##1 refresh_active [*8] ##1 refresh_active [*3];
  endsequence

  ack_onehot_a:
    assert property ($onehot0(ack)) else $error("more than one ack");
  ack_req_a:
    assert property (ack_q != 12'h000 |-> (ack_q & ~$past(req_eff)) == 12'h000)
    else $error("ack to idle or disabled requester");
  grant_space_a:
    assert property (ce && ack_q != 12'h000 |=> ack_q == 12'h000 [*8])
    else $error("grants closer than a decision period");
  xfer_len_a:
    assert property (mem_start && gap_q != 5'h00 |-> gap_q >= XFER_CYC)
    else $error("transaction shorter than its slot");
  rfsh_len_a:
    assert property (ce && $rose(refresh_active) |-> rf_hold_s ##1
      !refresh_active) else $error("refresh length wrong");
  wctl_rst_a:
    assert property ($fell(srst) |-> wctl_q == WCTL_RST)
    else $error("weights not cleared by reset");
  cpu_prio_a:
    assert property (ack_q[IDX_DCACHE] |-> !$past(cand[IDX_MMIO]))
    else $error("data cache beat register access");
  exc_sticky_a:
    assert property (ce && rt_fault != 5'h00 |=>
      (exc_q & $past(rt_fault)) == $past(rt_fault))
    else $error("exception flag lost");
  work_cons_a:
    assert property (ce && dec_pt && cand != 12'h000 |=> ack_q != 12'h000)
    else $error("idle decision with requests pending");
endmodule

// ===== rtl/whma_pkg.sv
// Constants and types shared by the weighted hierarchical memory arbiter
package whma_pkg;

  // Requester count and bit positions in the request vector
  localparam int NREQ = 12;
  localparam int IDX_MMIO = 0;
  localparam int IDX_DCACHE = 1;
  localparam int IDX_ICACHE = 2;
  localparam int IDX_VO = 3;
  localparam int IDX_ICP = 4;
  localparam int IDX_VI = 5;
  localparam int IDX_PCI = 6;
  localparam int L6_BASE = 7;
  localparam int L6_N = 5;
  localparam int NLVL = 5;

  // Register byte addresses
  localparam logic [20:0] RAISE_OFS = 21'h100100;
  localparam logic [20:0] WCTL_OFS = 21'h100104;
  localparam logic [20:0] CFG_OFS = 21'h100110;
  localparam logic [20:0] RFSH_OFS = 21'h100114;
  localparam logic [20:0] STAT_OFS = 21'h100118;

  // Writable bit masks and values after reset
  localparam logic [31:0] WCTL_MASK = 32'h0003FFFF;
  localparam logic [31:0] RAISE_MASK = 32'h0000FFFF;
  localparam logic [31:0] CFG_MASK = 32'h0000FFF7;
  localparam logic [31:0] RFSH_MASK = 32'h0000FFFF;
  localparam logic [31:0] WCTL_RST = 32'h00000000;
  localparam logic [31:0] RAISE_RST = 32'h00000000;
  localparam logic [31:0] CFG_RST = 32'h0000FFF0;
  localparam logic [31:0] RFSH_RST = 32'h000004C4;

  // Weight control field positions
  localparam int W_CPU_LSB = 16;
  localparam int W_L2_LSB = 14;
  localparam int W_VO_LSB = 12;
  localparam int W_L3_LSB = 10;
  localparam int W_ICP_LSB = 8;
  localparam int W_L4_LSB = 6;
  localparam int W_VI_BIT = 5;
  localparam int W_L5_LSB = 3;
  localparam int W_PCI_LSB = 1;
  localparam int W_L6_BIT = 0;

  // Other field positions
  localparam int CFG_RATIO_LSB = 0;
  localparam int CFG_EN_LSB = 4;
  localparam int RAISE_FLD_W = 4;
  localparam int STAT_ST_LSB = 8;
  localparam int STAT_OWN_LSB = 12;
  // Requesters with a raise delay: video out, video in, PCI, decoder
  localparam logic [15:0] RAISE_MAP = 16'h7653;

  // Processor/SDRAM clock ratio per code 0..4: 1, 5/4, 4/3, 3/2, 2/1
  localparam logic [14:0] RATIO_NUM = {3'h2, 3'h3, 3'h4, 3'h5, 3'h1};
  localparam logic [14:0] RATIO_DEN = {3'h1, 3'h2, 3'h3, 3'h4, 3'h1};

  // Cycle counts in SDRAM clocks; raise unit in processor clocks, block size in bytes
  localparam logic [4:0] XFER_CYC = 5'h14;
  localparam logic [4:0] EXTRA_CYC = 5'h0A;
  localparam logic [4:0] RFSH_CYC = 5'h13;
  localparam logic [4:0] DECIDE_CYC = 5'h10;
  localparam logic [11:0] RAISE_UNIT = 12'h010;
  localparam logic [6:0] XFER_BYTES = 7'h40;

  typedef struct packed {
    logic boot_loader;
    logic disc_stream_unit;
    logic audio_output_unit;
    logic audio_input_unit;
    logic variable_length_decoder;
    logic pci_unit;
    logic video_input_unit;
    logic image_coprocessor;
    logic video_output_unit;
    logic icache;
    logic dcache;
    logic cpu_mmio;
  } whma_req_t;

  typedef struct packed {
    logic digital_audio_output_unit;
    logic audio_input_unit;
    logic audio_output_unit;
    logic video_input_unit;
    logic video_output_unit;
  } whma_fault_t;

  typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_RFSH} whma_state_t;

endpackage

// ===== verif/whma_arbiter_tb.sv
// Self-checking bench for the weighted hierarchical memory arbiter
`timescale 1ns/1ps
module whma_arbiter_tb;
  import whma_pkg::*;

  logic core_clk, srst, ce, avs_read, avs_write, avs_waitrequest;
  logic [20:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable, mem_owner;
  logic [6:0] mem_bytes;
  logic [7:0] gap;
  logic cpu_reorder, mem_start, refresh_active;
  whma_req_t want, req, ack;
  whma_fault_t rt_fault;
  int mismatches, comparisons, maxgap, mingap;
  int cnt [NREQ];

  whma_arbiter i_whma_arbiter (.core_clk(core_clk), .srst(srst), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .req(req), .cpu_reorder(cpu_reorder), .rt_fault(rt_fault), .ack(ack),
    .mem_start(mem_start), .mem_owner(mem_owner), .mem_bytes(mem_bytes),
    .refresh_active(refresh_active));

  whma_req_model i_whma_req_model (.core_clk(core_clk), .srst(srst),
    .want(want), .gap(gap), .ack(ack), .req(req));

  // 50 MHz core clock
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Verdict and end of run
  task automatic test_done();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Counts settle within one grant of the ideal share
  task automatic near(input int seen, input int exp);
    check(32'(seen >= exp - 1 && seen <= exp + 1), 32'h1);
  endtask

  task automatic limit(input int t, input int m);
    if (t >= m)
    begin
      mismatches++;
      test_done();
    end
  endtask

  // One Avalon access; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [20:0] a,
    input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    limit(n, 50);
    @(posedge core_clk);
  endtask

  task automatic do_reset();
    want <= 12'h000;
    cpu_reorder <= 1'b0;
    rt_fault <= 5'h00;
    srst <= 1'b1;
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
  endtask

  // Watch n grants, counting per requester and spacing of starts
  task automatic grants(input int n);
    int k, t, s;
    k = 0;
    t = 0;
    s = -1;
    maxgap = 0;
    mingap = 999;
    foreach (cnt[i]) cnt[i] = 0;
    while (k < n && t < 5000)
    begin
      @(posedge core_clk);
      t++;
      check(32'($onehot0(ack)), 32'h1);
      foreach (cnt[i]) cnt[i] += int'(ack[i] === 1'b1);
      k += int'(ack !== 12'h000);
      if (s >= 0)
        s++;
      if (mem_start === 1'b1)
      begin
        if (s > maxgap)
          maxgap = s;
        if (s > 0 && s < mingap)
          mingap = s;
        s = 0;
      end
    end
    limit(t, 5000);
  endtask

  task automatic t_regs();
    do_reset();
    bus(1'b0, WCTL_OFS, 32'h0, 4'hF);
    check(q, 32'h0);
    bus(1'b0, CFG_OFS, 32'h0, 4'hF);
    check(q, 32'h0000FFF0);
    bus(1'b0, RFSH_OFS, 32'h0, 4'hF);
    check(q, 32'h000004C4);
    bus(1'b0, 21'h100108, 32'h0, 4'hF);
    check(q, 32'h0);
    bus(1'b1, WCTL_OFS, 32'hFFFFFFFF, 4'h1);
    bus(1'b0, WCTL_OFS, 32'h0, 4'hF);
    check(q, 32'h000000FF);
    bus(1'b1, WCTL_OFS, 32'hFFFFFFFF, 4'hF);
    bus(1'b0, WCTL_OFS, 32'h0, 4'hF);
    check(q, 32'h0003FFFF);
  endtask

  // Clock enable low freezes the arbiter although a request is waiting
  task automatic t_single();
    do_reset();
    check(mem_bytes, 32'h0);
    ce <= 1'b0;
    want <= 12'h008;
    repeat (4) @(posedge core_clk);
    check(ack, 32'h0);
    check(mem_owner, 32'h0);
    check(mem_start, 32'h0);
    ce <= 1'b1;
    grants(1);
    @(posedge core_clk);
    check(mem_bytes, 32'h40);
    check(mem_owner, 32'h3);
  endtask

  // Default weights: processor half, video output and coprocessor a quarter
  task automatic t_share();
    do_reset();
    want <= 12'h01A;
    grants(40);
    near(cnt[IDX_DCACHE], 20);
    near(cnt[IDX_VO], 10);
    near(cnt[IDX_ICP], 10);
    check(mingap, 20);
    check(maxgap, 20);
  endtask

  // Level one weights 3:1 and 1:3 split grants in that ratio
  task automatic t_weight();
    logic [31:0] w [2] = '{32'h00020000, 32'h00008000};
    int e [2] = '{30, 10};
    for (int i = 0; i < 2; i++)
    begin
      do_reset();
      bus(1'b1, WCTL_OFS, w[i], 4'hF);
      want <= 12'h00A;
      grants(40);
      near(cnt[IDX_DCACHE], e[i]);
      near(cnt[IDX_VO], 40 - e[i]);
    end
  endtask

  task automatic t_disable();
    do_reset();
    bus(1'b1, CFG_OFS, 32'h0000FF70, 4'hF);
    want <= 12'h01A;
    grants(30);
    check(cnt[IDX_VO], 0);
    near(cnt[IDX_ICP], 15);
    do_reset();
    want <= 12'h010;
    grants(10);
    check(cnt[IDX_ICP], 10);
    do_reset();
    want <= 12'h007;
    grants(1);
    check(cnt[IDX_MMIO], 1);
  endtask

  task automatic t_refresh();
    int t;
    do_reset();
    bus(1'b1, RFSH_OFS, 32'h28, 4'hF);
    want <= 12'h002;
    t = 0;
    while (refresh_active !== 1'b1 && t < 2000)
    begin
      @(posedge core_clk);
      t++;
    end
    limit(t, 2000);
    t = 0;
    while (refresh_active === 1'b1 && t < 100)
    begin
      check(mem_start, 32'h0);
      @(posedge core_clk);
      t++;
    end
    check(t, 19);
  endtask

  task automatic t_reorder();
    do_reset();
    cpu_reorder <= 1'b1;
    want <= 12'h00A;
    grants(10);
    check(maxgap, 30);
    check(mingap, 20);
  endtask

  // Raise after 16 cycles at ratio 1 and ratio 2/1; none when delay is 0
  task automatic t_raise();
    logic [31:0] r [3] = '{32'h0, 32'h00000100, 32'h00000200};
    logic [31:0] c [3] = '{32'h0000FFF0, 32'h0000FFF0, 32'h0000FFF4};
    for (int i = 0; i < 3; i++)
    begin
      do_reset();
      bus(1'b1, WCTL_OFS, 32'h00020000, 4'hF);
      bus(1'b1, RAISE_OFS, r[i], 4'hF);
      bus(1'b1, CFG_OFS, c[i], 4'hF);
      want <= 12'h042;
      grants(20);
      check(32'(cnt[IDX_PCI] >= 8), 32'(i > 0));
    end
  endtask

  task automatic t_fault();
    do_reset();
    rt_fault <= 5'h02;
    @(posedge core_clk);
    rt_fault <= 5'h00;
    repeat (3) @(posedge core_clk);
    bus(1'b0, STAT_OFS, 32'h0, 4'hF);
    check(q & 32'h1F, 32'h2);
    bus(1'b1, STAT_OFS, 32'h2, 4'hF);
    bus(1'b0, STAT_OFS, 32'h0, 4'hF);
    check(q & 32'h1F, 32'h0);
  endtask

  // Bottom level: decoder takes two turns for each audio turn
  task automatic t_bottom();
    do_reset();
    want <= 12'h180;
    grants(30);
    near(cnt[L6_BASE], 20);
    near(cnt[L6_BASE + 1], 10);
  endtask

  // Main sequence
  initial
  begin
    srst = 1'b1;
    ce = 1'b1;
    avs_address = 21'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    want = 12'h000;
    gap = 8'h00;
    cpu_reorder = 1'b0;
    rt_fault = 5'h00;
    mismatches = 0;
    comparisons = 0;
    t_regs();
    t_single();
    t_share();
    t_weight();
    t_disable();
    t_refresh();
    t_reorder();
    t_raise();
    t_fault();
    t_bottom();
    test_done();
  end
endmodule

// ===== verif/whma_req_model.sv
// Requester side model: posts one request, holds it until acked
`timescale 1ns/1ps
module whma_req_model (
  input wire logic core_clk, // SDRAM clock
  input wire logic srst, // synchronous reset
  input wire whma_pkg::whma_req_t want, // units that keep asking
  input wire logic [7:0] gap, // idle cycles after an ack
  input wire whma_pkg::whma_req_t ack, // grant pulses
  output whma_pkg::whma_req_t req // requests to the arbiter
);
  import whma_pkg::*;

  logic [NREQ-1:0][7:0] idle_q;

  // A request is never withdrawn before its ack, so reset ends a scenario
  always_ff @(posedge core_clk)
  begin
    for (int i = 0; i < NREQ; i++)
    begin
      if (srst)
      begin
        req[i] <= 1'b0;
        idle_q[i] <= 8'h00;
      end
      else if (ack[i])
      begin
        req[i] <= 1'b0;
        idle_q[i] <= gap;
      end
      else if (idle_q[i] != 8'h00)
        idle_q[i] <= idle_q[i] - 8'h01;
      else
        req[i] <= req[i] | want[i];
    end
  end
endmodule
